// ### core/scc_pkg.sv
// Package of constants, types and decode helpers for the system clock control.
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Divide-by-16 boot option leaves clock mode 0x1c, watchdog off, slow RC on.
// - Divide-by-32 boot option leaves clock mode 0x7c, 500KHz from 16MHz, no watchdog.
// - Slow-RC boot option leaves clock mode 0xe4, fast RC off, watchdog on.
// - With calibration off, clock mode keeps its reset value; watchdog stays on.
// - Crystal control bit 7 turns the crystal oscillator on or off.
// - Crystal control bits 6:5 set drive strength: 01 low, 10 middle, 11 high.
// - A clock mode write switches source and divider at once, no delay.
// - Clock mode bit 4 enables the fast internal RC oscillator.
// - Writing 0x34 selects fast RC divided by 2, slow RC kept running.
// - Writing 0xf4 selects the slow RC, fast RC kept enabled.
// - Writing 0xb0 selects the crystal oscillator, fast RC kept enabled.
// - Writing 0x14 from fast RC divide-by-2 moves to fast RC divide-by-4.
// - Crystal, fast RC and slow RC each have an independent enable bit.
//////////////////////////////////////////////////////////////////////////////
package scc_pkg;

  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;

  localparam logic [5:0] CLOCK_MODE_ADDR = 6'h03;
  localparam logic [5:0] XTAL_CTRL_ADDR = 6'h0a;
  localparam logic [5:0] CLOCK_STATUS_ADDR = 6'h3f;

  // Clock mode fields.
  localparam int CM_SEL_HI = 7;
  localparam int CM_SEL_LO = 5;
  localparam int CM_FAST_EN = 4;
  localparam int CM_TYPE = 3;
  localparam int CM_SLOW_EN = 2;
  localparam int CM_WDT_EN = 1;

  // Crystal control fields.
  localparam int XC_EN = 7;
  localparam int XC_DRV_HI = 6;
  localparam int XC_DRV_LO = 5;
  localparam logic [7:0] XC_WRITE_MASK = 8'he0;
  localparam logic [7:0] XTAL_CTRL_RESET = 8'h00;

  // Clock mode values after reset, picked by the boot-up time option.
  localparam logic [7:0] CLOCK_MODE_RESET_FAST = 8'h9c;
  localparam logic [7:0] CLOCK_MODE_RESET_SLOW = 8'he4;

  // Post-boot clock mode values of the calibration options.
  localparam logic [7:0] BOOT_DIV2 = 8'h34;
  localparam logic [7:0] BOOT_DIV4 = 8'h14;
  localparam logic [7:0] BOOT_DIV8 = 8'h3c;
  localparam logic [7:0] BOOT_DIV16 = 8'h1c;
  localparam logic [7:0] BOOT_DIV32 = 8'h7c;
  localparam logic [7:0] BOOT_SLOW = 8'he4;

  // Source select codes in clock mode bits 7:5.
  localparam logic [2:0] SEL_FAST_A = 3'h0;
  localparam logic [2:0] SEL_FAST_B = 3'h1;
  localparam logic [2:0] SEL_FAST_C = 3'h3;
  localparam logic [2:0] SEL_FAST_64 = 3'h4;
  localparam logic [2:0] SEL_XTAL = 3'h5;

  typedef enum logic [2:0] {
    CAL_DIV2 = 3'b000,
    CAL_DIV4 = 3'b001,
    CAL_DIV8 = 3'b010,
    CAL_DIV16 = 3'b011,
    CAL_DIV32 = 3'b100,
    CAL_SLOW = 3'b101,
    CAL_OFF = 3'b110
  } scc_cal_e;

  typedef enum logic [1:0] {
    SRC_FAST = 2'b00,
    SRC_SLOW = 2'b01,
    SRC_XTAL = 2'b10
  } scc_src_e;

  typedef enum logic [1:0] {
    DRV_OFF = 2'b00,
    DRV_LOW = 2'b01,
    DRV_MID = 2'b10,
    DRV_HIGH = 2'b11
  } scc_drive_e;

  typedef enum logic {
    ST_BOOT = 1'b0,
    ST_RUN = 1'b1
  } scc_state_e;

  // Selected source and divider as a power of two, zero meaning undivided.
  typedef struct packed {
    scc_src_e src;
    logic [2:0] div_log;
  } scc_clk_sel_s;

  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } scc_bus_req_s;

  // Maps a clock mode value onto the source and divider it selects.
  function automatic scc_clk_sel_s decode_clock_mode(input logic [7:0] mode);
    scc_clk_sel_s sel;
    logic t;
    sel = '{src: SRC_SLOW, div_log: 3'h0};
    t = mode[CM_TYPE];
    case (mode[CM_SEL_HI:CM_SEL_LO])
      SEL_FAST_A: sel = '{src: SRC_FAST, div_log: (t ? 3'h4 : 3'h2)};
      SEL_FAST_B: sel = '{src: SRC_FAST, div_log: (t ? 3'h3 : 3'h1)};
      SEL_FAST_C: sel = '{src: SRC_FAST, div_log: 3'h5};
      SEL_FAST_64: sel = '{src: SRC_FAST, div_log: 3'h6};
      SEL_XTAL: sel = '{src: SRC_XTAL, div_log: 3'h0};
      default: sel = '{src: SRC_SLOW, div_log: 3'h0};
    endcase
    return sel;
  endfunction

  // Post-boot clock mode of a calibration option; reset value when it is off.
  function automatic logic [7:0] boot_clock_mode(input scc_cal_e cal,
                                                 input logic [7:0] rst_val);
    logic [7:0] v;
    v = rst_val;
    case (cal)
      CAL_DIV2: v = BOOT_DIV2;
      CAL_DIV4: v = BOOT_DIV4;
      CAL_DIV8: v = BOOT_DIV8;
      CAL_DIV16: v = BOOT_DIV16;
      CAL_DIV32: v = BOOT_DIV32;
      CAL_SLOW: v = BOOT_SLOW;
      default: v = rst_val;
    endcase
    return v;
  endfunction

endpackage

// ### core/scc_clk_gen.sv
// System clock generator: picks one oscillator and divides it.
`timescale 1ns/1ns
module scc_clk_gen (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic restart,
  input wire scc_pkg::scc_clk_sel_s sel,
  input wire logic fast_rc_in,
  input wire logic slow_rc_in,
  input wire logic xtal_in,
  output logic sys_clk_out
);

  logic fast_q;
  logic slow_q;
  logic xtal_q;
  logic src_now;
  logic src_prev;
  logic [4:0] edge_count;
  logic [4:0] half_count;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      fast_q <= 1'b0;
      slow_q <= 1'b0;
      xtal_q <= 1'b0;
    end else begin
      fast_q <= fast_rc_in;
      slow_q <= slow_rc_in;
      xtal_q <= xtal_in;
    end
  end

  always_comb begin
    case (sel.src)
      scc_pkg::SRC_FAST: src_now = fast_q;
      scc_pkg::SRC_XTAL: src_now = xtal_q;
      default: src_now = slow_q;
    endcase
    half_count = (sel.div_log == 3'h0) ? 5'h00 :
                 5'((6'h01 << (sel.div_log - 3'h1)) - 6'h01);
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      src_prev <= 1'b0;
    end else begin
      src_prev <= src_now;
    end
  end

  // A write restarts the divider so the new setting counts from its first
  // source edge; a stopped source simply freezes the output.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      edge_count <= 5'h00;
      sys_clk_out <= 1'b0;
    end else if (restart) begin
      edge_count <= 5'h00;
      sys_clk_out <= 1'b0;
    end else if (sel.div_log == 3'h0) begin
      sys_clk_out <= src_now;
    end else if (src_now && !src_prev) begin
      if (edge_count == half_count) begin
        edge_count <= 5'h00;
        sys_clk_out <= ~sys_clk_out;
      end else begin
        edge_count <= edge_count + 5'h01;
      end
    end
  end

endmodule // scc_clk_gen

// ### core/scc_clock_ctrl.sv
// Top of the system clock control: registers, boot load and oscillator enables.
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ns
module scc_clock_ctrl #(
  parameter scc_pkg::scc_cal_e CAL_OPTION = scc_pkg::CAL_DIV16,
  parameter logic FAST_BOOT = 1'b0
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic fast_rc_in,
  input wire logic slow_rc_in,
  input wire logic xtal_in,
  output logic sys_clk_out,
  output logic fast_rc_enable,
  output logic slow_rc_enable,
  output logic xtal_enable,
  output logic [1:0] xtal_drive,
  output logic watchdog_enable,
  output logic boot_done
);

  //////////////////////////////////////////////////////////////////////////////
  // Boot constants.

  localparam logic [7:0] RESET_MODE = FAST_BOOT ?
    scc_pkg::CLOCK_MODE_RESET_FAST : scc_pkg::CLOCK_MODE_RESET_SLOW;
  localparam logic [7:0] BOOT_MODE =
    scc_pkg::boot_clock_mode(CAL_OPTION, RESET_MODE);
  // Calibrated fast-RC options leave the watchdog off; slow RC and no
  // calibration leave it running.
  localparam logic BOOT_WDT = (CAL_OPTION == scc_pkg::CAL_SLOW) ||
                              (CAL_OPTION == scc_pkg::CAL_OFF);

  scc_pkg::scc_state_e state;
  scc_pkg::scc_bus_req_s req;
  scc_pkg::scc_clk_sel_s sel;
  logic [7:0] clock_mode;
  logic [7:0] xtal_ctrl;
  logic boot_wdt;
  logic mode_write;
  logic xtal_write;
  logic restart;
  logic [7:0] next_rdata;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  //////////////////////////////////////////////////////////////////////////////
  // Boot sequence.

  // The first cycle after reset loads the post-boot value; bus writes in that
  // cycle are dropped, not held, and a read in it returns the raw reset value.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state <= scc_pkg::ST_BOOT;
    end else begin
      case (state)
        scc_pkg::ST_BOOT: state <= scc_pkg::ST_RUN;
        scc_pkg::ST_RUN: state <= scc_pkg::ST_RUN;
        default: state <= scc_pkg::ST_BOOT;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      boot_done <= 1'b0;
    end else begin
      boot_done <= (state == scc_pkg::ST_BOOT) || boot_done;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Address decode.

  always_comb begin
    mode_write = 1'b0;
    xtal_write = 1'b0;
    if (req.wr && state == scc_pkg::ST_RUN) begin
      if (req.addr == scc_pkg::CLOCK_MODE_ADDR) begin
        mode_write = 1'b1;
      end else if (req.addr == scc_pkg::XTAL_CTRL_ADDR) begin
        xtal_write = 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Clock mode register.

  // Every value is taken as written. Stopping the running oscillator in the
  // same write as a source change is left to software, since the hardware
  // cannot tell a safe order from an unsafe one.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      clock_mode <= RESET_MODE;
    end else if (state == scc_pkg::ST_BOOT) begin
      clock_mode <= BOOT_MODE;
    end else if (mode_write) begin
      clock_mode <= req.wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      boot_wdt <= 1'b0;
    end else if (state == scc_pkg::ST_BOOT) begin
      boot_wdt <= BOOT_WDT;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Crystal oscillator control register.

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      xtal_ctrl <= scc_pkg::XTAL_CTRL_RESET;
    end else if (xtal_write) begin
      xtal_ctrl <= req.wdata & scc_pkg::XC_WRITE_MASK;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Oscillator enables and drive.

  // Each oscillator follows only its own bit; none is stopped implicitly
  // when it is deselected.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      fast_rc_enable <= 1'b0;
      slow_rc_enable <= 1'b0;
      xtal_enable <= 1'b0;
      xtal_drive <= scc_pkg::DRV_OFF;
      watchdog_enable <= 1'b0;
    end else begin
      fast_rc_enable <= clock_mode[scc_pkg::CM_FAST_EN];
      slow_rc_enable <= clock_mode[scc_pkg::CM_SLOW_EN];
      xtal_enable <= xtal_ctrl[scc_pkg::XC_EN];
      xtal_drive <= xtal_ctrl[scc_pkg::XC_DRV_HI:scc_pkg::XC_DRV_LO];
      watchdog_enable <= boot_wdt || clock_mode[scc_pkg::CM_WDT_EN];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Clock selection and generation.

  // Selection is decoded straight from the register, so the generator
  // follows a write on the next edge. No crystal stability check is made:
  // selecting an unsettled crystal gives an unsettled system clock.
  assign sel = scc_pkg::decode_clock_mode(clock_mode);
  assign restart = (state == scc_pkg::ST_BOOT) || mode_write;

  scc_clk_gen u_clk_gen (
    .clock(clock),
    .sys_rst(sys_rst),
    .restart(restart),
    .sel(sel),
    .fast_rc_in(fast_rc_in),
    .slow_rc_in(slow_rc_in),
    .xtal_in(xtal_in),
    .sys_clk_out(sys_clk_out)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Read path.

  always_comb begin
    next_rdata = 8'h00;
    if (req.rd) begin
      if (req.addr == scc_pkg::CLOCK_MODE_ADDR) begin
        next_rdata = clock_mode;
      end else if (req.addr == scc_pkg::XTAL_CTRL_ADDR) begin
        next_rdata = xtal_ctrl;
      end else if (req.addr == scc_pkg::CLOCK_STATUS_ADDR) begin
        next_rdata = {boot_done, watchdog_enable, 1'b0, sel.src, sel.div_log};
      end
    end
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule // scc_clock_ctrl

// ### testbench/scc_clock_ctrl_chk.sv
// Port assertions for the system clock control.
`timescale 1ns/1ns
module scc_clock_ctrl_chk (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic sys_clk_out,
  input wire logic fast_rc_enable,
  input wire logic slow_rc_enable,
  input wire logic xtal_enable,
  input wire logic [1:0] xtal_drive,
  input wire logic watchdog_enable,
  input wire logic boot_done
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic cm_wr;
  logic xc_wr;
  // Boot done is a safe subset of the run state, so no write is missed.
  assign cm_wr = reg_wr && reg_addr == scc_pkg::CLOCK_MODE_ADDR && boot_done;
  assign xc_wr = reg_wr && reg_addr == scc_pkg::XTAL_CTRL_ADDR && boot_done;
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  a_xtal_low_zero: assert property ($past(reg_rd) &&
    $past(reg_addr) == scc_pkg::XTAL_CTRL_ADDR |-> reg_rdata[4:0] == 5'h00)
    else $error("crystal control low bits not zero");
  a_fast_en_follow: assert property (cm_wr |-> ##2
    fast_rc_enable == $past(reg_wdata[4], 2)) else $error("fast enable");
  a_slow_en_follow: assert property (cm_wr |-> ##2
    slow_rc_enable == $past(reg_wdata[2], 2)) else $error("slow enable");
  a_xtal_en_follow: assert property (xc_wr |-> ##2
    xtal_enable == $past(reg_wdata[7], 2)) else $error("crystal enable");
  a_drive_follow: assert property (xc_wr |-> ##2
    xtal_drive == $past(reg_wdata[6:5], 2)) else $error("drive strength");
  a_wdog_follow: assert property (cm_wr |-> ##2
    watchdog_enable == $past(reg_wdata[1], 2)) else $error("watchdog");
  a_switch_restart: assert property (cm_wr |-> ##1 !sys_clk_out)
    else $error("clock not restarted");
  a_boot_seq: assert property ($past(sys_rst) && !sys_rst |->
    !boot_done ##1 boot_done ##1 boot_done) else $error("boot timing");
  a_boot_enables: assert property ($rose(boot_done) |->
    ##1 fast_rc_enable && slow_rc_enable && !watchdog_enable)
    else $error("post-boot enables");
  c_mode_write: cover property (cm_wr);
  c_xtal_on: cover property ($rose(xtal_enable));
  c_clk_rise: cover property ($rose(sys_clk_out));
endmodule // scc_clock_ctrl_chk
bind scc_clock_ctrl scc_clock_ctrl_chk u_chk (.*);

// ### testbench/scc_xtal_model.sv
// Behavioural crystal that starts only after a delay once enabled.
`timescale 1ns/1ns
module scc_xtal_model #(
  parameter int STARTUP = 64
) (
  input wire logic clock,
  input wire logic enable,
  input wire logic [1:0] drive,
  output logic xtal_out
);
  int start_cnt = 0;
  int half_cnt = 0;
  initial xtal_out = 1'b0;
  // With no drive current the crystal never builds up, so it stands still.
  always @(posedge clock) begin
    if (!enable || drive == 2'b00) begin
      start_cnt <= 0;
      half_cnt <= 0;
      xtal_out <= 1'b0;
    end else if (start_cnt < STARTUP) begin
      start_cnt <= start_cnt + 1;
    end else if (half_cnt == 2) begin
      half_cnt <= 0;
      xtal_out <= !xtal_out;
    end else begin
      half_cnt <= half_cnt + 1;
    end
  end
endmodule // scc_xtal_model

// ### testbench/system_clock_source_control_test.sv
// Self-checking bench for the system clock control.
`timescale 1ns/1ns
module system_clock_source_control_test;
  localparam int WIN = 512;
  localparam int STARTUP = 64;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [5:0] reg_addr = 6'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic fast_rc_in = 1'b0;
  logic slow_rc_in = 1'b0;
  logic xtal_in;
  logic [7:0] reg_rdata;
  logic sys_clk_out, fast_rc_enable, slow_rc_enable, xtal_enable;
  logic watchdog_enable, boot_done;
  logic [1:0] xtal_drive;
  int n_errors = 0;
  int cmp_count = 0;
  logic [31:0] seed = 32'h0452315a;
  logic fast_ph = 1'b0;
  int slow_cnt = 0;
  logic [7:0] xr;
  logic [5:0] ua;
  // Every source change keeps the old oscillator running for one write.
  logic [7:0] modes [9] = '{8'h34, 8'h14, 8'hb0, 8'h34, 8'h3c, 8'h7e,
    8'h9c, 8'hf4, 8'he4};
  initial begin
    forever #4 clock = !clock;
  end
  scc_clock_ctrl dut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .fast_rc_in(fast_rc_in), .slow_rc_in(slow_rc_in),
    .xtal_in(xtal_in), .sys_clk_out(sys_clk_out),
    .fast_rc_enable(fast_rc_enable), .slow_rc_enable(slow_rc_enable),
    .xtal_enable(xtal_enable), .xtal_drive(xtal_drive),
    .watchdog_enable(watchdog_enable), .boot_done(boot_done));
  scc_xtal_model #(.STARTUP(STARTUP)) u_xtal (.clock(clock),
    .enable(xtal_enable), .drive(xtal_drive), .xtal_out(xtal_in));
  // The RC oscillators run only while enabled: periods of 4 and 14 cycles.
  always @(posedge clock) begin
    if (fast_rc_enable === 1'b1) begin
      fast_ph <= !fast_ph;
      if (fast_ph) fast_rc_in <= !fast_rc_in;
    end
    if (slow_rc_enable === 1'b1) begin
      slow_cnt <= (slow_cnt == 6) ? 0 : slow_cnt + 1;
      if (slow_cnt == 6) slow_rc_in <= !slow_rc_in;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // Status is {done, watchdog, 0, source, log2 of divider}.
  function automatic logic [7:0] exp_status(input logic [7:0] m);
    logic [4:0] sd;
    case (m[7:5])
      3'h0: sd = m[3] ? 5'h04 : 5'h02;
      3'h1: sd = m[3] ? 5'h03 : 5'h01;
      3'h3: sd = 5'h05;
      3'h4: sd = 5'h06;
      3'h5: sd = 5'h10;
      default: sd = 5'h08;
    endcase
    return {1'b1, m[1], 1'b0, sd};
  endfunction
  task automatic chk(input string what, input logic [7:0] e,
                     input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", what, e, g);
      n_errors++;
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e,
                    input string what);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    chk(what, e, reg_rdata);
  endtask
  task automatic check_mode(input logic [7:0] m);
    int r;
    int e;
    logic [7:0] st;
    logic prev;
    st = exp_status(m);
    rd(scc_pkg::CLOCK_MODE_ADDR, m, "clock_mode");
    rd(scc_pkg::CLOCK_STATUS_ADDR, st, "status");
    chk("fast_en", {7'h00, m[4]}, {7'h00, fast_rc_enable});
    chk("slow_en", {7'h00, m[2]}, {7'h00, slow_rc_enable});
    r = 0;
    prev = sys_clk_out;
    repeat (WIN) begin
      @(negedge clock);
      if (sys_clk_out === 1'b1 && prev === 1'b0) r++;
      prev = sys_clk_out;
    end
    e = WIN / ((st[4] ? 6 : (st[3] ? 14 : 4)) << st[2:0]);
    // Window phase may gain or lose one edge.
    if (r == e + 1 || r == e - 1) r = e;
    chk("clock_rises", 8'(e), 8'(r));
    $display("test mode %h done", m);
  endtask
  task automatic conclude();
    $display("counts: %0d compares, %0d mismatches", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clock);
    check_mode(8'h1c);
    wr(scc_pkg::XTAL_CTRL_ADDR, 8'he0);
    rd(scc_pkg::XTAL_CTRL_ADDR, 8'he0, "xtal_ctrl");
    repeat (STARTUP + 8) @(posedge clock);
    foreach (modes[i]) begin
      wr(scc_pkg::CLOCK_MODE_ADDR, modes[i]);
      check_mode(modes[i]);
    end
    xr = 8'he0;
    for (int i = 0; i < 24; i++) begin
      seed = xorshift(seed);
      ua = 6'h10 | seed[12:9];
      wr(seed[8] ? scc_pkg::XTAL_CTRL_ADDR : ua, seed[7:0]);
      if (seed[8]) xr = seed[7:0] & 8'he0;
      rd(scc_pkg::XTAL_CTRL_ADDR, xr, "xtal_ctrl");
      chk("xtal_en", {7'h00, xr[7]}, {7'h00, xtal_enable});
      chk("drive", {6'h00, xr[6:5]}, {6'h00, xtal_drive});
      rd(ua, 8'h00, "unmapped");
    end
    $display("test random crystal control done");
    wr(scc_pkg::XTAL_CTRL_ADDR, 8'h00);
    rd(scc_pkg::XTAL_CTRL_ADDR, 8'h00, "xtal_off");
    wr(scc_pkg::CLOCK_STATUS_ADDR, 8'h00);
    rd(scc_pkg::CLOCK_STATUS_ADDR, exp_status(8'he4), "status_ro");
    $display("test read-only status done");
    conclude();
  end
  // About 5400 cycles are expected; over five times that means a hang.
  initial begin
    #(8 * 30000);
    n_errors++;
    $display("mismatch watchdog expected finish seen timeout");
    conclude();
  end
endmodule // system_clock_source_control_test
